// file: ishc_regs.vh
`ifndef ISHC_REGS_VH
`define ISHC_REGS_VH

// ----------------------------------------------------------------
// Register bus geometry
// ----------------------------------------------------------------
`define ISHC_ADDR_W 12
`define ISHC_DATA_W 32
`define ISHC_ZERO32 32'h00000000

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define ISHC_OFF_IRQ_STATUS 12'h00C
`define ISHC_OFF_HW_CONFIG 12'h010
`define ISHC_OFF_IRQ_MASK 12'h100
`define ISHC_OFF_IRQ_EVENT 12'h104
`define ISHC_OFF_ATTACH_GPIO 12'h108

// ----------------------------------------------------------------
// Interrupt status fields
// ----------------------------------------------------------------
`define ISHC_BIT_TX_OFF 19
`define ISHC_BIT_RX_OFF 18
`define ISHC_BIT_PHY 17
`define ISHC_BIT_DPORT 16
`define ISHC_BIT_MACERR 15
`define ISHC_BIT_TXPEND 12
`define ISHC_GPIO_N 12
`define ISHC_GPIO_ZERO 12'h000
`define ISHC_STS_W1C_MASK 32'h000F8FFF
`define ISHC_STS_RD_MASK 32'h000F9FFF

// ----------------------------------------------------------------
// Hardware configuration fields
// ----------------------------------------------------------------
`define ISHC_CFG_GIGCLK 25
`define ISHC_CFG_REFCLK 24
`define ISHC_CFG_DET_STAT 15
`define ISHC_CFG_DET_EN 14
`define ISHC_CFG_PROTECT 12

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define ISHC_RST_BIT 1'b0
`define ISHC_PIN_IDLE 14'h0001
`define ISHC_INIT_CNT_W 2
`define ISHC_INIT_ZERO 2'h0
`define ISHC_INIT_DONE 2'h2
`define ISHC_INIT_STEP 2'h1

`endif

// file: ishc_sync2.v
`default_nettype none

// ----------------------------------------------------------------
// Two-stage synchroniser, one pair of flops per bit
// ----------------------------------------------------------------
module ishc_sync2 #(
	parameter integer WIDTH = 1,
	parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);

	reg [WIDTH-1:0] stage1;
	reg [WIDTH-1:0] stage2;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
			// First flop feeds only the second flop
			always @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					stage1[g] <= RESET_VALUE[g];
					stage2[g] <= RESET_VALUE[g];
				end else begin
					stage1[g] <= async_i[g];
					stage2[g] <= stage1[g];
				end
			end
		end
	endgenerate

	assign sync_o = stage2;

endmodule // ishc_sync2

`default_nettype wire

// file: ishc_top.v
// Notes on behaviour
// - Bit 19 follows transmit-side disabled levels
// - Bit 18 follows receive-side disabled levels
// - Bit 17 reflects active-low PHY interrupt pin
// - Bit 16 set on data port completion
// - Bit 15 held while any MAC error pending
// - Bit 12 read-only transmit frame pending flag
// - Twelve GPIO bits; clearing also clears wake
// - GPIO bits initialise from pin levels
// - Config bit 25 enables internal gigabit clock
// - Config bit 24 enables reference clock output
// - Config bit 15 records detach/reattach event
// - Config bit 14 detaches from USB
// - Link or chosen GPIO reattaches, sets flag
// - Protected clock enables survive non-power-on resets
`default_nettype none
`include "ishc_regs.vh"

module ishc_top (
	input wire clk_i,
	input wire rst_n_i,
	input wire por_n_i,
	// Register port
	input wire [`ISHC_ADDR_W-1:0] addr_i,
	input wire [`ISHC_DATA_W-1:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [`ISHC_DATA_W-1:0] rdata_o,
	// Interrupt sources from same-clock logic
	input wire fifo_transmit_disabled_i,
	input wire mac_transmit_disabled_i,
	input wire fifo_receive_disabled_i,
	input wire mac_receive_disabled_i,
	input wire data_port_done_i,
	input wire mac_error_pending_i,
	input wire usb_tx_frame_pending_i,
	// Pins
	input wire external_phy_irq_pin_n_i,
	input wire phy_link_i,
	input wire [`ISHC_GPIO_N-1:0] gpio_i,
	// Outputs
	output reg [`ISHC_GPIO_N-1:0] gpio_wake_clear_o,
	output wire internal_gig_clock_enable_o,
	output wire reference_clock_out_enable_o,
	output wire usb_detach_o,
	output wire irq_o
);

	// ----------------------------------------------------------------
	// Address decode helper
	// ----------------------------------------------------------------
	function hit;
		input [`ISHC_ADDR_W-1:0] a;
		input [`ISHC_ADDR_W-1:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	wire [`ISHC_GPIO_N+1:0] pins_sync;
	wire [`ISHC_GPIO_N-1:0] gpio_sync;
	wire phy_irq_n_sync;
	wire phy_link_sync;
	wire rst_n_sync;

	// GPIOs, link and PHY interrupt pin; PHY pin idles high
	ishc_sync2 #(
		.WIDTH(`ISHC_GPIO_N + 2),
		.RESET_VALUE(`ISHC_PIN_IDLE)
	) u_pin_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.async_i({gpio_i, phy_link_i, external_phy_irq_pin_n_i}),
		.sync_o(pins_sync)
	);

	// Ordinary reset seen from the power-on domain
	ishc_sync2 #(
		.WIDTH(1),
		.RESET_VALUE(1'b0)
	) u_rst_sync (
		.clk_i(clk_i),
		.rst_n_i(por_n_i),
		.async_i(rst_n_i),
		.sync_o(rst_n_sync)
	);

	assign gpio_sync = pins_sync[`ISHC_GPIO_N+1:2];
	assign phy_link_sync = pins_sync[1];
	assign phy_irq_n_sync = pins_sync[0];

	// ----------------------------------------------------------------
	// Bus strobes
	// ----------------------------------------------------------------
	wire wr_status = wr_i & hit(addr_i, `ISHC_OFF_IRQ_STATUS);
	wire wr_config = wr_i & hit(addr_i, `ISHC_OFF_HW_CONFIG);
	wire wr_mask = wr_i & hit(addr_i, `ISHC_OFF_IRQ_MASK);
	wire wr_attach = wr_i & hit(addr_i, `ISHC_OFF_ATTACH_GPIO);
	wire rd_event = rd_i & hit(addr_i, `ISHC_OFF_IRQ_EVENT);

	// Write-one-clear strobes, only on clearable bits
	wire [31:0] clr_status = wr_status ? (wdata_i & `ISHC_STS_W1C_MASK) : `ISHC_ZERO32;

	// ----------------------------------------------------------------
	// Interrupt status sources
	// ----------------------------------------------------------------
	wire src_tx_off = fifo_transmit_disabled_i | mac_transmit_disabled_i;
	wire src_rx_off = fifo_receive_disabled_i | mac_receive_disabled_i;
	wire src_phy = ~phy_irq_n_sync;
	wire src_dport = data_port_done_i;
	wire src_macerr = mac_error_pending_i;

	reg [31:0] src_vec;

	// Gather sources into register layout
	always @* begin
		src_vec = `ISHC_ZERO32;
		src_vec[`ISHC_BIT_TX_OFF] = src_tx_off;
		src_vec[`ISHC_BIT_RX_OFF] = src_rx_off;
		src_vec[`ISHC_BIT_PHY] = src_phy;
		src_vec[`ISHC_BIT_DPORT] = src_dport;
		src_vec[`ISHC_BIT_MACERR] = src_macerr;
		src_vec[`ISHC_GPIO_N-1:0] = gpio_sync;
	end

	// ----------------------------------------------------------------
	// Interrupt status register
	// ----------------------------------------------------------------
	reg [31:0] irq_status;
	reg tx_frame_pending;
	reg [`ISHC_INIT_CNT_W-1:0] init_cnt;
	wire init_done = (init_cnt == `ISHC_INIT_DONE);
	reg [31:0] next_irq_status;

	// Level sources hold their bit; set wins over a clear
	always @* begin
		next_irq_status = ((irq_status & ~clr_status) | src_vec) & `ISHC_STS_W1C_MASK;
		if (!init_done) begin
			next_irq_status[`ISHC_GPIO_N-1:0] = gpio_sync;
		end
	end

	// Count synchroniser fill after reset release
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			init_cnt <= `ISHC_INIT_ZERO;
		end else if (!init_done) begin
			init_cnt <= init_cnt + `ISHC_INIT_STEP;
		end
	end

	// Status storage
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_status <= `ISHC_ZERO32;
			tx_frame_pending <= `ISHC_RST_BIT;
		end else begin
			irq_status <= next_irq_status;
			tx_frame_pending <= usb_tx_frame_pending_i;
		end
	end

	// Clearing a GPIO bit clears its wake event too
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gpio_wake_clear_o <= `ISHC_GPIO_ZERO;
		end else begin
			gpio_wake_clear_o <= clr_status[`ISHC_GPIO_N-1:0];
		end
	end

	// Readable view including the read-only pending bit
	reg [31:0] status_view;
	always @* begin
		status_view = irq_status;
		status_view[`ISHC_BIT_TXPEND] = tx_frame_pending;
	end

	// ----------------------------------------------------------------
	// Protected clock enables and reset protection
	// ----------------------------------------------------------------
	reg gig_clk_en;
	reg ref_clk_en;
	reg rst_protect;

	// Power-on reset clears these; other resets clear the enables unless protected
	always @(posedge clk_i or negedge por_n_i) begin
		if (!por_n_i) begin
			gig_clk_en <= `ISHC_RST_BIT;
			ref_clk_en <= `ISHC_RST_BIT;
			rst_protect <= `ISHC_RST_BIT;
		end else if (!rst_n_sync) begin
			if (!rst_protect) begin
				gig_clk_en <= `ISHC_RST_BIT;
				ref_clk_en <= `ISHC_RST_BIT;
			end
		end else if (wr_config) begin
			gig_clk_en <= wdata_i[`ISHC_CFG_GIGCLK];
			ref_clk_en <= wdata_i[`ISHC_CFG_REFCLK];
			rst_protect <= wdata_i[`ISHC_CFG_PROTECT];
		end
	end

	assign internal_gig_clock_enable_o = gig_clk_en;
	assign reference_clock_out_enable_o = ref_clk_en;

	// ----------------------------------------------------------------
	// Cable-driven detach and reattach
	// ----------------------------------------------------------------
	reg detach_en;
	reg detach_status;
	reg [`ISHC_GPIO_N-1:0] attach_gpio_sel;
	wire reattach = detach_en & (phy_link_sync | (|(gpio_sync & attach_gpio_sel)));
	wire clr_detach_status = wr_config & wdata_i[`ISHC_CFG_DET_STAT];

	// Detach control, self-clearing on reattach
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			detach_en <= `ISHC_RST_BIT;
			detach_status <= `ISHC_RST_BIT;
			attach_gpio_sel <= `ISHC_GPIO_ZERO;
		end else begin
			if (reattach) begin
				detach_en <= `ISHC_RST_BIT;
			end else if (wr_config && wdata_i[`ISHC_CFG_DET_EN]) begin
				detach_en <= 1'b1;
			end
			// Event set wins over a software clear
			if (reattach) begin
				detach_status <= 1'b1;
			end else if (clr_detach_status) begin
				detach_status <= `ISHC_RST_BIT;
			end
			if (wr_attach) begin
				attach_gpio_sel <= wdata_i[`ISHC_GPIO_N-1:0];
			end
		end
	end

	assign usb_detach_o = detach_en;

	reg [31:0] config_view;
	always @* begin
		config_view = `ISHC_ZERO32;
		config_view[`ISHC_CFG_GIGCLK] = gig_clk_en;
		config_view[`ISHC_CFG_REFCLK] = ref_clk_en;
		config_view[`ISHC_CFG_DET_STAT] = detach_status;
		config_view[`ISHC_CFG_DET_EN] = detach_en;
		config_view[`ISHC_CFG_PROTECT] = rst_protect;
	end

	// ----------------------------------------------------------------
	// Interrupt output: sticky events, mask, read-clear
	// ----------------------------------------------------------------
	reg [31:0] irq_mask;
	reg [31:0] irq_event;
	reg [31:0] status_prev;
	wire [31:0] rising = status_view & ~status_prev;
	reg [31:0] next_irq_event;

	// Newly raised bits set events; set wins over read-clear
	always @* begin
		next_irq_event = rd_event ? `ISHC_ZERO32 : irq_event;
		next_irq_event = (next_irq_event | rising) & `ISHC_STS_RD_MASK;
	end

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_mask <= `ISHC_ZERO32;
			irq_event <= `ISHC_ZERO32;
			status_prev <= `ISHC_ZERO32;
		end else begin
			irq_event <= next_irq_event;
			status_prev <= status_view;
			if (wr_mask) begin
				irq_mask <= wdata_i & `ISHC_STS_RD_MASK;
			end
		end
	end

	assign irq_o = |(irq_event & irq_mask);

	// ----------------------------------------------------------------
	// Read data, one cycle after the strobe
	// ----------------------------------------------------------------
	reg [31:0] next_rdata;
	always @* begin
		next_rdata = `ISHC_ZERO32;
		if (rd_i) begin
			case (addr_i)
				`ISHC_OFF_IRQ_STATUS: next_rdata = status_view;
				`ISHC_OFF_HW_CONFIG: next_rdata = config_view;
				`ISHC_OFF_IRQ_MASK: next_rdata = irq_mask;
				`ISHC_OFF_IRQ_EVENT: next_rdata = irq_event;
				`ISHC_OFF_ATTACH_GPIO: next_rdata = {20'h00000, attach_gpio_sel};
				default: next_rdata = `ISHC_ZERO32;
			endcase
		end
	end

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= `ISHC_ZERO32;
		end else begin
			rdata_o <= next_rdata;
		end
	end

endmodule // ishc_top

`default_nettype wire

// file: ishc_phy_model.sv
`default_nettype none
// ----------------------------------------------------------------
// External PHY: latched interrupt and link
// ----------------------------------------------------------------
module ishc_phy_model (
	input wire logic clk_i,
	input wire logic raise_i,
	input wire logic clear_i,
	input wire logic link_i,
	output var logic irq_pin_n_o = 1'b1,
	output logic link_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pin stays low until the event is cleared inside the PHY
	always @(posedge clk_i) begin
		if (clear_i)
			irq_pin_n_o <= 1'b1;
		else if (raise_i)
			irq_pin_n_o <= 1'b0;
	end
	// Link indication straight to the pin
	assign link_o = link_i;
endmodule // ishc_phy_model
`default_nettype wire

// file: ishc_top_properties.sv
`default_nettype none
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module ishc_top_properties (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic por_n_i,
	input wire logic [11:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic fifo_transmit_disabled_i,
	input wire logic mac_transmit_disabled_i,
	input wire logic fifo_receive_disabled_i,
	input wire logic mac_receive_disabled_i,
	input wire logic mac_error_pending_i,
	input wire logic external_phy_irq_pin_n_i,
	input wire logic phy_link_i,
	input wire logic [11:0] gpio_wake_clear_o,
	input wire logic reference_clock_out_enable_o,
	input wire logic usb_detach_o,
	input wire logic irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i || !por_n_i);
	logic rd_sts;
	// Status read strobe
	assign rd_sts = rd_i && addr_i == 12'h00C;
	property p_tx; (fifo_transmit_disabled_i || mac_transmit_disabled_i)[*3] ##0 rd_sts
		|=> rdata_o[19]; endproperty
	a_tx: assert property (p_tx) else $error("tx disabled bit lost");
	property p_rx; (fifo_receive_disabled_i || mac_receive_disabled_i)[*3] ##0 rd_sts
		|=> rdata_o[18]; endproperty
	a_rx: assert property (p_rx) else $error("rx disabled bit lost");
	property p_phy; (!external_phy_irq_pin_n_i)[*5] ##0 rd_sts |=> rdata_o[17]; endproperty
	a_phy: assert property (p_phy) else $error("phy bit lost");
	property p_merr; mac_error_pending_i[*3] ##0 rd_sts |=> rdata_o[15]; endproperty
	a_merr: assert property (p_merr) else $error("mac error bit lost");
	property p_wake; gpio_wake_clear_o != 12'h000 |-> $past(wr_i && addr_i == 12'h00C)
		&& (gpio_wake_clear_o & ~$past(wdata_i[11:0])) == 12'h000; endproperty
	a_wake: assert property (p_wake) else $error("stray wake clear");
	property p_ref; wr_i && addr_i == 12'h010 |=> reference_clock_out_enable_o
		== $past(wdata_i[24]); endproperty
	a_ref: assert property (p_ref) else $error("refclk enable wrong");
	property p_det; $rose(usb_detach_o) |-> $past(wr_i && addr_i == 12'h010 && wdata_i[14]);
	endproperty
	a_det: assert property (p_det) else $error("detach without write");
	property p_reatt; usb_detach_o && phy_link_i |-> ##[1:5] !usb_detach_o; endproperty
	a_reatt: assert property (p_reatt) else $error("no reattach on link");
	c_irq: cover property (irq_o);
	c_reatt: cover property ($fell(usb_detach_o));
	c_wake: cover property (gpio_wake_clear_o != 12'h000);
endmodule // ishc_top_properties
bind ishc_top ishc_top_properties u_props (.*);
`default_nettype wire

// file: ishc_top_test.sv
`default_nettype none
module ishc_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst_n = 1'b0, por_n = 1'b0, wr = 1'b0, rd = 1'b0, dp = 1'b0;
	logic pend = 1'b0, raise = 1'b0, clr = 1'b0, link = 1'b0, pin_n, link_s;
	logic gig, ref_en, det, irq;
	logic [11:0] addr = 12'h000, gpio = 12'hA5A, wake;
	logic [31:0] wdata = 32'h00000000, rdata;
	logic [4:0] lvl = 5'h00;
	int mismatches = 0, n_compared = 0;
	// ----------------------------------------------------------------
	// Design and PHY
	// ----------------------------------------------------------------
	ishc_top u_dut (.clk_i(clk), .rst_n_i(rst_n), .por_n_i(por_n), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.fifo_transmit_disabled_i(lvl[0]), .mac_transmit_disabled_i(lvl[1]),
		.fifo_receive_disabled_i(lvl[2]), .mac_receive_disabled_i(lvl[3]),
		.data_port_done_i(dp), .mac_error_pending_i(lvl[4]), .usb_tx_frame_pending_i(pend),
		.external_phy_irq_pin_n_i(pin_n), .phy_link_i(link_s), .gpio_i(gpio),
		.gpio_wake_clear_o(wake), .internal_gig_clock_enable_o(gig),
		.reference_clock_out_enable_o(ref_en), .usb_detach_o(det), .irq_o(irq));
	ishc_phy_model u_phy (.clk_i(clk), .raise_i(raise), .clear_i(clr), .link_i(link),
		.irq_pin_n_o(pin_n), .link_o(link_s));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	initial forever #20 clk = ~clk;
	task idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata & m, e);
		// Return on a rising edge so callers drive right after it
		@(posedge clk);
	endtask
	task stop_test;
		if (mismatches == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_levels;
		int i;
		int b[5] = '{19, 19, 18, 18, 15};
		for (i = 0; i < 5; i++) begin
			lvl[i] <= 1'b1;
			idle(3);
			wr_reg(12'h00C, 32'h1 << b[i]);
			rd_chk(12'h00C, 32'h1 << b[i], 32'h1 << b[i]);
			idle(1);
			lvl[i] <= 1'b0;
			wr_reg(12'h00C, 32'h1 << b[i]);
			rd_chk(12'h00C, 32'h0, 32'h1 << b[i]);
			idle(1);
		end
	endtask
	task t_dport;
		// Events so far: GPIO levels after reset and the three level sources
		rd_chk(12'h104, 32'h000C8A5A, 32'hFFFFFFFF);
		dp <= 1'b1;
		idle(1);
		dp <= 1'b0;
		idle(3);
		chk({31'h0, irq}, 32'h0);
		wr_reg(12'h100, 32'h00010000);
		@(negedge clk);
		chk({31'h0, irq}, 32'h1);
		wr_reg(12'h00C, 32'h0);
		rd_chk(12'h00C, 32'h00010000, 32'h00010000);
		rd_chk(12'h104, 32'h00010000, 32'h00010000);
		chk({31'h0, irq}, 32'h0);
		wr_reg(12'h00C, 32'h00010000);
		rd_chk(12'h00C, 32'h0, 32'h00010000);
	endtask
	task t_phy_pend;
		idle(1);
		raise <= 1'b1;
		pend <= 1'b1;
		idle(6);
		wr_reg(12'h00C, 32'h00021000);
		rd_chk(12'h00C, 32'h00021000, 32'h00021000);
		clr <= 1'b1;
		pend <= 1'b0;
		idle(5);
		wr_reg(12'h00C, 32'h00020000);
		rd_chk(12'h00C, 32'h0, 32'h00021000);
	endtask
	task t_gpio;
		gpio <= 12'h000;
		idle(4);
		wr_reg(12'h00C, 32'h00000A5A);
		@(negedge clk);
		chk({20'h0, wake}, 32'h00000A5A);
		rd_chk(12'h00C, 32'h0, 32'h00000FFF);
	endtask
	task t_cfg;
		wr_reg(12'h010, 32'h03001000);
		rst_n <= 1'b0;
		idle(4);
		rst_n <= 1'b1;
		idle(4);
		rd_chk(12'h010, 32'h03001000, 32'hFFFFFFFF);
		chk({30'h0, gig, ref_en}, 32'h3);
		por_n <= 1'b0;
		rst_n <= 1'b0;
		idle(2);
		por_n <= 1'b1;
		rst_n <= 1'b1;
		idle(4);
		rd_chk(12'h010, 32'h0, 32'hFFFFFFFF);
		// Unprotected enables fall to an ordinary reset
		wr_reg(12'h010, 32'h03000000);
		rst_n <= 1'b0;
		idle(4);
		rst_n <= 1'b1;
		idle(4);
		rd_chk(12'h010, 32'h0, 32'hFFFFFFFF);
		chk({30'h0, gig, ref_en}, 32'h0);
	endtask
	task t_det(input logic by_pin);
		wr_reg(12'h108, 32'h00000001);
		wr_reg(12'h010, 32'h00004000);
		@(negedge clk);
		chk({31'h0, det}, 32'h1);
		@(posedge clk);
		link <= !by_pin;
		gpio <= {11'h0, by_pin};
		idle(6);
		chk({31'h0, det}, 32'h0);
		link <= 1'b0;
		gpio <= 12'h000;
		rd_chk(12'h010, 32'h00008000, 32'h0000C000);
		wr_reg(12'h010, 32'h00008000);
		rd_chk(12'h010, 32'h0, 32'h0000C000);
	endtask
	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		idle(5);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		idle(4);
		rd_chk(12'h00C, 32'h00000A5A, 32'hFFFFFFFF);
		rd_chk(12'h004, 32'h0, 32'hFFFFFFFF);
		t_levels();
		t_dport();
		t_phy_pend();
		t_gpio();
		t_cfg();
		t_det(1'b0);
		t_det(1'b1);
		stop_test();
	end
	initial begin
		idle(3000);
		mismatches++;
		stop_test();
	end
endmodule // ishc_top_test
`default_nettype wire
